// >>> hdl/srb_pkg.sv
// Constants, types and helpers shared by the serial receive buffer and its readout engine.
// Assumes one 50 MHz clock, an APB register bus and byte-wide receivers in front of each port.
// Operation
// - Read runs only when execute bit set
// - Copy bytes two per destination word
// - Move only bytes received, no stale fill
// - Refuse bytes while 256 unread held
// - Destination beyond area end flags error
// - Order digit selects byte packing order
// - Peripheral done flag set, read clears
// - RS-232C done flag set, read clears
// - Peripheral byte counter, read zeroes it
// - RS-232C byte counter, read zeroes it
// - Zero count only clears flag, counter
// - Port reset bit clears flags, counter
// - Missing port or bad setup flags error
package srb_pkg;

  // Register indexes; byte address is four times the index.
  localparam logic [11:0] IDX_CTRL = 12'h100;
  localparam logic [11:0] IDX_NBYTES = 12'h101;
  localparam logic [11:0] IDX_DEST = 12'h102;
  localparam logic [11:0] IDX_AREA_END = 12'h103;
  localparam logic [11:0] IDX_STATUS = 12'h104;
  localparam logic [11:0] IDX_RS232_RX_BYTE_COUNT = 12'h109;
  localparam logic [11:0] IDX_PERIPH_RX_BYTE_COUNT = 12'h10a;

  // Control register fields.
  localparam int CTRL_EXEC_BIT = 0;
  localparam int CTRL_PORT_BIT = 1;
  localparam int CTRL_ORDER_BIT = 4;
  localparam int CTRL_PERIPH_RESET_BIT = 8;
  localparam int CTRL_RS232_RESET_BIT = 9;

  // Status register fields.
  localparam int STAT_PERIPH_DONE_BIT = 0;
  localparam int STAT_RS232_DONE_BIT = 1;
  localparam int STAT_ERROR_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  // Reset values.
  localparam logic [15:0] NBYTES_RESET = 16'h0000;
  localparam logic [15:0] DEST_RESET = 16'h0000;
  localparam logic [15:0] AREA_END_RESET = 16'hffff;
  localparam logic [8:0] COUNT_RESET = 9'h000;

  // Buffer geometry and request limit.
  localparam logic [8:0] BUF_DEPTH = 9'h100;
  localparam logic [13:0] NBYTES_MAX = 14'h0100;

  localparam logic PORT_PERIPH = 1'b0;
  localparam logic PORT_RS232 = 1'b1;

  typedef enum logic {
    SRB_IDLE,
    SRB_XFER
  } srb_state_t;

  // One destination word leaving the readout engine.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } srb_word_t;

  // One received byte arriving from a port receiver.
  typedef struct packed {
    logic valid;
    logic ok;
    logic [7:0] data;
  } srb_rx_t;

  typedef struct packed {
    logic ok;
    logic [8:0] val;
  } srb_bcd_t;

  // Decodes a four digit BCD count and checks it against the request limit.
  function automatic srb_bcd_t srb_bcd(input logic [15:0] n);
    srb_bcd_t r;
    logic [13:0] v;
    logic digits_ok;
    digits_ok = (n[15:12] <= 4'h9) && (n[11:8] <= 4'h9) && (n[7:4] <= 4'h9) && (n[3:0] <= 4'h9);
    v = 14'({10'h000, n[15:12]} * 14'd1000) + 14'({10'h000, n[11:8]} * 14'd100)
      + 14'({10'h000, n[7:4]} * 14'd10) + {10'h000, n[3:0]};
    r.ok = digits_ok && (v <= NBYTES_MAX);
    r.val = v[8:0];
    return r;
  endfunction

endpackage

// >>> hdl/srb_rx_port.sv
// One port's receive buffer: 256 bytes of flip-flops, a byte counter and a done flag.
// Assumes the receiver presents one byte per valid pulse and flags error-free completion with ok.
`timescale 1ns/1ps
module srb_rx_port
  import srb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Receiver side
  input wire srb_rx_t rx,
  output logic rx_ready,
  // Readout side
  input wire logic hold,
  input wire logic clr,
  input wire logic [7:0] rd_idx_a,
  input wire logic [7:0] rd_idx_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  output logic [8:0] count,
  output logic done
);

  logic [7:0] mem_q [0:255];
  logic [7:0] mem_d [0:255];
  logic [8:0] count_q;
  logic [8:0] count_d;
  logic done_q;
  logic done_d;
  logic take;

  // A full buffer refuses bytes; so does a port the engine is draining.
  assign rx_ready = (count_q < BUF_DEPTH) && !hold;
  assign take = rx.valid && rx_ready;

  always_comb begin
    mem_d = mem_q;
    count_d = count_q;
    done_d = done_q;
    if (clr) begin
      count_d = COUNT_RESET;
      done_d = 1'b0;
    end
    // A byte or completion arriving with the clear survives it, landing at index 0.
    if (take) begin
      mem_d[clr ? 8'h00 : count_q[7:0]] = rx.data;
      count_d = clr ? 9'h001 : 9'(count_q + 9'h001);
    end
    if (rx.ok) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= 8'h00;
      end
      count_q <= COUNT_RESET;
      done_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign rd_data_a = mem_q[rd_idx_a];
  assign rd_data_b = mem_q[rd_idx_b];
  assign count = count_q;
  assign done = done_q;

endmodule

// >>> hdl/srb_top.sv
// Receive buffering for the peripheral and RS-232C ports with an APB-controlled readout engine.
// Assumes APB from a master on mclk and a destination memory that accepts words on valid and ready.
`timescale 1ns/1ps
module srb_top
  import srb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Peripheral port receiver
  input wire srb_rx_t periph_rx,
  output logic periph_rx_ready,
  // RS-232C port receiver
  input wire srb_rx_t rs232_rx,
  output logic rs232_rx_ready,
  // Unit configuration and attachment status
  input wire logic has_rs232,
  input wire logic periph_attached,
  input wire logic rs232_attached,
  input wire logic settings_ok,
  // Destination word output
  output logic dst_valid,
  output srb_word_t dst_word,
  input wire logic dst_ready,
  // Error indication
  output logic instruction_error_flag
);

  srb_state_t state_q;
  srb_state_t state_d;
  logic port_sel_q;
  logic port_sel_d;
  logic order_q;
  logic order_d;
  logic [15:0] nbytes_q;
  logic [15:0] nbytes_d;
  logic [15:0] dest_q;
  logic [15:0] dest_d;
  logic [15:0] area_end_q;
  logic [15:0] area_end_d;
  logic err_q;
  logic err_d;
  logic xfer_port_q;
  logic xfer_port_d;
  logic xfer_order_q;
  logic xfer_order_d;
  logic [8:0] idx_q;
  logic [8:0] idx_d;
  logic [8:0] total_q;
  logic [8:0] total_d;
  logic [15:0] waddr_q;
  logic [15:0] waddr_d;
  logic dst_valid_q;
  logic dst_valid_d;
  srb_word_t dst_word_q;
  srb_word_t dst_word_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  logic setup;
  logic wr_access;
  logic [11:0] widx;
  logic [11:0] ridx;
  logic exec_req;
  logic periph_reset_req;
  logic rs232_reset_req;
  logic read_clear;
  logic clr_periph;
  logic clr_rs232;
  logic [7:0] periph_a;
  logic [7:0] periph_b;
  logic [7:0] rs232_a;
  logic [7:0] rs232_b;
  logic [8:0] periph_count;
  logic [8:0] rs232_count;
  logic periph_done;
  logic rs232_done;
  logic [7:0] byte_a;
  logic [7:0] byte_b;
  logic [8:0] sel_count;
  srb_bcd_t bcd;
  logic [8:0] words_req;
  logic [16:0] last_word;
  logic range_bad;
  logic port_ok;
  logic start_err;
  logic [8:0] idx_next;

  // Setup captures read data so that the access phase completes without wait states.
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign widx = paddr[13:2];
  assign ridx = paddr[13:2];
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  assign exec_req = wr_access && (widx == IDX_CTRL) && pwdata[CTRL_EXEC_BIT];
  assign periph_reset_req = wr_access && (widx == IDX_CTRL) && pwdata[CTRL_PERIPH_RESET_BIT];
  assign rs232_reset_req = wr_access && (widx == IDX_CTRL) && pwdata[CTRL_RS232_RESET_BIT];

  // Read or port reset bit clears one port's counter and done flag.
  assign clr_periph = (read_clear && (xfer_port_d == PORT_PERIPH)) || periph_reset_req;
  assign clr_rs232 = (read_clear && (xfer_port_d == PORT_RS232)) || rs232_reset_req;

  srb_rx_port u_periph (
    .mclk(mclk),
    .reset(reset),
    .rx(periph_rx),
    .rx_ready(periph_rx_ready),
    .hold((state_q == SRB_XFER) && (xfer_port_q == PORT_PERIPH)),
    .clr(clr_periph),
    .rd_idx_a(idx_q[7:0]),
    .rd_idx_b(idx_next[7:0]),
    .rd_data_a(periph_a),
    .rd_data_b(periph_b),
    .count(periph_count),
    .done(periph_done)
  );

  srb_rx_port u_rs232 (
    .mclk(mclk),
    .reset(reset),
    .rx(rs232_rx),
    .rx_ready(rs232_rx_ready),
    .hold((state_q == SRB_XFER) && (xfer_port_q == PORT_RS232)),
    .clr(clr_rs232),
    .rd_idx_a(idx_q[7:0]),
    .rd_idx_b(idx_next[7:0]),
    .rd_data_a(rs232_a),
    .rd_data_b(rs232_b),
    .count(rs232_count),
    .done(rs232_done)
  );

  assign idx_next = 9'(idx_q + 9'h001);
  assign byte_a = (xfer_port_q == PORT_RS232) ? rs232_a : periph_a;
  // A missing second byte reads as zero rather than leftover buffer contents.
  assign byte_b = (idx_next < total_q) ? ((xfer_port_q == PORT_RS232) ? rs232_b : periph_b) : 8'h00;
  assign sel_count = (port_sel_d == PORT_RS232) ? rs232_count : periph_count;

  // Start checks use the control value being written so one write both selects and executes.
  assign bcd = srb_bcd(nbytes_q);
  assign words_req = 9'((bcd.val + 9'h001) >> 1);
  assign last_word = 17'({1'b0, dest_q} + {8'h00, words_req}) - 17'h00001;
  assign range_bad = (words_req != 9'h000) && (last_word > {1'b0, area_end_q});
  assign port_ok = (port_sel_d == PORT_RS232) ? (has_rs232 && rs232_attached) : periph_attached;
  assign start_err = !bcd.ok || range_bad || !port_ok || !settings_ok;

  always_comb begin
    state_d = state_q;
    port_sel_d = port_sel_q;
    order_d = order_q;
    nbytes_d = nbytes_q;
    dest_d = dest_q;
    area_end_d = area_end_q;
    err_d = err_q;
    xfer_port_d = xfer_port_q;
    xfer_order_d = xfer_order_q;
    idx_d = idx_q;
    total_d = total_q;
    waddr_d = waddr_q;
    dst_valid_d = dst_valid_q;
    dst_word_d = dst_word_q;
    read_clear = 1'b0;
    if (dst_valid_q && dst_ready) begin
      dst_valid_d = 1'b0;
    end
    if (wr_access && (state_q == SRB_IDLE)) begin
      case (widx)
        IDX_CTRL: begin
          port_sel_d = pwdata[CTRL_PORT_BIT];
          order_d = pwdata[CTRL_ORDER_BIT];
        end
        IDX_NBYTES: nbytes_d = pwdata[15:0];
        IDX_DEST: dest_d = pwdata[15:0];
        IDX_AREA_END: area_end_d = pwdata[15:0];
        default: ;
      endcase
    end
    case (state_q)
      SRB_IDLE: begin
        if (exec_req) begin
          xfer_port_d = port_sel_d;
          xfer_order_d = order_d;
          err_d = start_err;
          if (!start_err) begin
            total_d = (bcd.val < sel_count) ? bcd.val : sel_count;
            idx_d = 9'h000;
            waddr_d = dest_q;
            if ((bcd.val == 9'h000) || (sel_count == 9'h000)) begin
              read_clear = 1'b1;
            end else begin
              state_d = SRB_XFER;
            end
          end
        end
      end
      SRB_XFER: begin
        if (!dst_valid_q || dst_ready) begin
          dst_valid_d = 1'b1;
          dst_word_d.addr = waddr_q;
          // Two bytes per word; order 0 puts the earlier byte high.
          dst_word_d.data = xfer_order_q ? {byte_b, byte_a} : {byte_a, byte_b};
          waddr_d = 16'(waddr_q + 16'h0001);
          idx_d = 9'(idx_q + 9'h002);
          if (9'(idx_q + 9'h002) >= total_q) begin
            read_clear = 1'b1;
            state_d = SRB_IDLE;
          end
        end
      end
      default: state_d = SRB_IDLE;
    endcase
  end

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      case (ridx)
        IDX_CTRL: begin
          prdata_d[CTRL_PORT_BIT] = port_sel_q;
          prdata_d[CTRL_ORDER_BIT] = order_q;
        end
        IDX_NBYTES: prdata_d[15:0] = nbytes_q;
        IDX_DEST: prdata_d[15:0] = dest_q;
        IDX_AREA_END: prdata_d[15:0] = area_end_q;
        IDX_STATUS: begin
          prdata_d[STAT_PERIPH_DONE_BIT] = periph_done;
          prdata_d[STAT_RS232_DONE_BIT] = rs232_done;
          prdata_d[STAT_ERROR_BIT] = err_q;
          prdata_d[STAT_BUSY_BIT] = (state_q == SRB_XFER);
        end
        IDX_RS232_RX_BYTE_COUNT: prdata_d[8:0] = rs232_count;
        IDX_PERIPH_RX_BYTE_COUNT: prdata_d[8:0] = periph_count;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= SRB_IDLE;
      port_sel_q <= PORT_PERIPH;
      order_q <= 1'b0;
      nbytes_q <= NBYTES_RESET;
      dest_q <= DEST_RESET;
      area_end_q <= AREA_END_RESET;
      err_q <= 1'b0;
      xfer_port_q <= PORT_PERIPH;
      xfer_order_q <= 1'b0;
      idx_q <= 9'h000;
      total_q <= 9'h000;
      waddr_q <= 16'h0000;
      dst_valid_q <= 1'b0;
      dst_word_q <= '0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      port_sel_q <= port_sel_d;
      order_q <= order_d;
      nbytes_q <= nbytes_d;
      dest_q <= dest_d;
      area_end_q <= area_end_d;
      err_q <= err_d;
      xfer_port_q <= xfer_port_d;
      xfer_order_q <= xfer_order_d;
      idx_q <= idx_d;
      total_q <= total_d;
      waddr_q <= waddr_d;
      dst_valid_q <= dst_valid_d;
      dst_word_q <= dst_word_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign dst_valid = dst_valid_q;
  assign dst_word = dst_word_q;
  assign instruction_error_flag = err_q;

endmodule

// >>> tb/srb_ser_dev.sv
// Behavioural serial device feeding one receive port of the buffer.
// Assumes the caller sits just after a rising edge; bytes are held until taken with ready high or 500 cycles pass.
`timescale 1ns/1ps
module srb_ser_dev
  import srb_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Receive port
  input wire logic rx_ready,
  output srb_rx_t rx
);
  initial rx = 10'h000;
  // A full buffer may keep ready low, so the wait is bounded and the byte is then given up.
  task automatic send(input logic [7:0] base, input int n);
    int t;
    for (int i = 0; i < n; i++) begin
      rx.valid <= 1'b1;
      rx.ok <= (i == n - 1);
      rx.data <= base + 8'(i);
      t = 0;
      @(negedge mclk);
      while (!rx_ready && t < 500) begin
        t++;
        @(negedge mclk);
      end
      @(posedge mclk);
    end
    rx.valid <= 1'b0;
    rx.ok <= 1'b0;
    rx.data <= ~rx.data;
  endtask
endmodule

// >>> tb/srb_top_props.sv
// Checker for the readout engine's destination stream and error flag.
// Assumes it is bound to srb_top and sees only that module's ports.
`timescale 1ns/1ps
module srb_top_props
  import srb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  // Unit status
  input wire logic has_rs232,
  input wire logic rs232_attached,
  input wire logic settings_ok,
  // Destination and error
  input wire logic dst_valid,
  input wire srb_word_t dst_word,
  input wire logic dst_ready,
  input wire logic instruction_error_flag
);
  logic wr, exec;
  logic [15:0] nbytes_q, nbytes_d, dest_q, dest_d, area_q, area_d;
  logic [8:0] wcnt_q, wcnt_d;
  assign wr = psel && penable && pwrite;
  assign exec = wr && paddr[13:2] == IDX_CTRL && pwdata[CTRL_EXEC_BIT];
  // Shadow copies of the request registers, so word addresses are judged from the bus alone.
  always_comb begin
    nbytes_d = (wr && paddr[13:2] == IDX_NBYTES) ? pwdata[15:0] : nbytes_q;
    dest_d = (wr && paddr[13:2] == IDX_DEST) ? pwdata[15:0] : dest_q;
    area_d = (wr && paddr[13:2] == IDX_AREA_END) ? pwdata[15:0] : area_q;
    wcnt_d = exec ? 9'h000 : wcnt_q + 9'(dst_valid && dst_ready);
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nbytes_q <= NBYTES_RESET;
      dest_q <= DEST_RESET;
      area_q <= AREA_END_RESET;
      wcnt_q <= 9'h000;
    end else begin
      nbytes_q <= nbytes_d;
      dest_q <= dest_d;
      area_q <= area_d;
      wcnt_q <= wcnt_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_first_addr; $rose(dst_valid) |-> dst_word.addr == dest_q; endproperty
  a_first_addr: assert property (p_first_addr) else $error("first word address wrong");
  property p_step; dst_valid && dst_ready ##1 dst_valid |-> dst_word.addr == $past(dst_word.addr) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("word address not consecutive");
  property p_hold; dst_valid && !dst_ready |=> dst_valid && $stable(dst_word); endproperty
  a_hold: assert property (p_hold) else $error("word dropped while stalled");
  property p_max_words; wcnt_q <= 9'h080; endproperty
  a_max_words: assert property (p_max_words) else $error("more than 128 words in one read");
  property p_after_exec; $rose(dst_valid) |-> $past(exec, 2); endproperty
  a_after_exec: assert property (p_after_exec) else $error("word without execute");
  property p_err_quiet; !exec |=> $stable(instruction_error_flag); endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flag moved without execute");
  property p_cfg_err; exec && !settings_ok |=> instruction_error_flag; endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("bad settings not flagged");
  property p_port_err; exec && pwdata[CTRL_PORT_BIT] && !(has_rs232 && rs232_attached) |=> instruction_error_flag;
  endproperty
  a_port_err: assert property (p_port_err) else $error("missing port not flagged");
  property p_zero; exec && nbytes_q == 16'h0000 |=> !dst_valid [*3]; endproperty
  a_zero: assert property (p_zero) else $error("zero count moved data");
  property p_area; dst_valid |-> dst_word.addr <= area_q; endproperty
  a_area: assert property (p_area) else $error("word beyond area end");
  c_xfer: cover property (dst_valid && dst_ready);
  c_stall: cover property (dst_valid && !dst_ready);
  c_err: cover property ($rose(instruction_error_flag));
endmodule

// >>> tb/srb_top_tb.sv
// Bench for the receive buffer readout: a table of reads, then error, area, full-buffer and reset cases.
// Assumes the package register map and the single-cycle APB answer of the design.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module srb_top_tb
  import srb_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, periph_rx_ready, rs232_rx_ready, dst_valid, instruction_error_flag;
  logic has_rs232 = 1'b1, periph_attached = 1'b1, rs232_attached = 1'b1, settings_ok = 1'b1;
  logic dst_ready = 1'b1, stall = 1'b0;
  srb_rx_t periph_rx, rs232_rx;
  srb_word_t dst_word;
  srb_word_t got[$];
  int n_mismatch = 0, check_count = 0, cyc = 0;
  typedef struct {logic prt; logic ord; logic [15:0] n; int nrx; int tot;} srb_row_t;
  srb_row_t rows[4] = '{'{1'b0, 1'b0, 16'h0004, 4, 4}, '{1'b1, 1'b1, 16'h0003, 5, 3},
    '{1'b0, 1'b0, 16'h0010, 3, 3}, '{1'b1, 1'b0, 16'h0000, 2, 0}};
  srb_top DUT(.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .periph_rx(periph_rx),
    .periph_rx_ready(periph_rx_ready), .rs232_rx(rs232_rx), .rs232_rx_ready(rs232_rx_ready),
    .has_rs232(has_rs232), .periph_attached(periph_attached), .rs232_attached(rs232_attached),
    .settings_ok(settings_ok), .dst_valid(dst_valid), .dst_word(dst_word), .dst_ready(dst_ready),
    .instruction_error_flag(instruction_error_flag));
  srb_ser_dev u_pe(.mclk(mclk), .rx_ready(periph_rx_ready), .rx(periph_rx));
  srb_ser_dev u_rs(.mclk(mclk), .rx_ready(rs232_rx_ready), .rx(rs232_rx));
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (dst_valid && dst_ready) got.push_back(dst_word);
    dst_ready <= stall ? !dst_ready : 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask
  task automatic run(input logic prt, input logic ord);
    int t;
    t = 0;
    apb(1'b1, IDX_CTRL, 32'h0000_0001 | 32'(prt) << CTRL_PORT_BIT | 32'(ord) << CTRL_ORDER_BIT);
    do begin
      apb(1'b0, IDX_STATUS, 32'h0000_0000);
      t++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && t < 400);
  endtask
  function automatic srb_word_t expw(logic [15:0] a, logic [7:0] b, int k, int tot, logic ord);
    logic [7:0] h, l;
    h = b + 8'(2 * k);
    l = (2 * k + 1 < tot) ? b + 8'(2 * k + 1) : 8'h00;
    expw.addr = a + 16'(k);
    expw.data = ord ? {l, h} : {h, l};
  endfunction
  initial begin
    logic [7:0] b;
    logic [15:0] d;
    logic [11:0] ci;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rchk(IDX_RS232_RX_BYTE_COUNT, 32'h0000_0000, "rs232 count");
    rchk(IDX_PERIPH_RX_BYTE_COUNT, 32'h0000_0000, "periph count");
    apb(1'b0, 12'h0ff, 32'h0000_0000);
    `CHK("pslverr", 1'b1, pslverr)
    for (int r = 0; r < 4; r++) begin
      b = 8'(8'h11 + 16 * r);
      d = 16'h0020 + 16'(16 * r);
      ci = rows[r].prt ? IDX_RS232_RX_BYTE_COUNT : IDX_PERIPH_RX_BYTE_COUNT;
      got.delete();
      if (rows[r].prt) u_rs.send(b, rows[r].nrx);
      else u_pe.send(b, rows[r].nrx);
      rchk(ci, 32'(rows[r].nrx), "count");
      rchk(IDX_STATUS, 32'h0000_0001 << rows[r].prt, "done");
      apb(1'b1, IDX_NBYTES, {16'h0000, rows[r].n});
      apb(1'b1, IDX_DEST, {16'h0000, d});
      run(rows[r].prt, rows[r].ord);
      `CHK("words", (rows[r].tot + 1) / 2, got.size())
      foreach (got[k]) `CHK("word", expw(d, b, k, rows[r].tot, rows[r].ord), got[k])
      rchk(ci, 32'h0000_0000, "count cleared");
      rchk(IDX_STATUS, 32'h0000_0000, "done cleared");
      $display("row %0d done", r);
    end
    got.delete();
    u_pe.send(8'h40, 2);
    apb(1'b1, IDX_CTRL, 32'h0000_0000);
    rchk(IDX_PERIPH_RX_BYTE_COUNT, 32'h0000_0002, "no exec");
    settings_ok <= 1'b0;
    run(1'b0, 1'b0);
    rchk(IDX_STATUS, 32'h0000_0005, "bad settings");
    settings_ok <= 1'b1;
    rs232_attached <= 1'b0;
    run(1'b1, 1'b0);
    rchk(IDX_STATUS, 32'h0000_0005, "no device");
    rs232_attached <= 1'b1;
    `CHK("no words", 0, got.size())
    apb(1'b1, IDX_CTRL, 32'h0000_0001 << CTRL_PERIPH_RESET_BIT);
    rchk(IDX_PERIPH_RX_BYTE_COUNT, 32'h0000_0000, "port reset");
    rchk(IDX_STATUS, 32'h0000_0004, "flags reset");
    $display("error test done");
    u_rs.send(8'h50, 4);
    apb(1'b1, IDX_NBYTES, 32'h0000_0004);
    apb(1'b1, IDX_AREA_END, 32'h0000_0030);
    apb(1'b1, IDX_DEST, 32'h0000_0030);
    run(1'b1, 1'b0);
    rchk(IDX_STATUS, 32'h0000_0006, "area overrun");
    apb(1'b1, IDX_DEST, 32'h0000_002f);
    run(1'b1, 1'b0);
    `CHK("area end", expw(16'h002f, 8'h50, 1, 4, 1'b0), got[$])
    apb(1'b1, IDX_AREA_END, 32'h0000_ffff);
    $display("area test done");
    // The full case also stalls the destination, so held words are exercised on a long read.
    u_pe.send(8'h00, 256);
    @(negedge mclk);
    `CHK("full", 1'b0, periph_rx_ready)
    @(posedge mclk);
    rchk(IDX_PERIPH_RX_BYTE_COUNT, 32'h0000_0100, "full count");
    stall <= 1'b1;
    got.delete();
    apb(1'b1, IDX_NBYTES, 32'h0000_0256);
    apb(1'b1, IDX_DEST, 32'h0000_0000);
    run(1'b0, 1'b0);
    stall <= 1'b0;
    `CHK("full words", 128, got.size())
    `CHK("last word", expw(16'h0000, 8'h00, 127, 256, 1'b0), got[$])
    @(negedge mclk);
    `CHK("ready again", 1'b1, periph_rx_ready)
    @(posedge mclk);
    $display("full test done");
    // A reset in mid-run must empty a partly filled buffer.
    u_rs.send(8'h60, 3);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK("ready after reset", 1'b1, rs232_rx_ready)
    rchk(IDX_RS232_RX_BYTE_COUNT, 32'h0000_0000, "count after reset");
    rchk(IDX_STATUS, 32'h0000_0000, "status after reset");
    $display("reset test done");
    complete_run();
  end
endmodule
bind srb_top srb_top_props u_props(.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .has_rs232(has_rs232), .rs232_attached(rs232_attached),
  .settings_ok(settings_ok), .dst_valid(dst_valid), .dst_word(dst_word), .dst_ready(dst_ready),
  .instruction_error_flag(instruction_error_flag));
